// ==== hdl/sbsp_port.sv ====
module sbsp_port
	import sbsp_pkg::*;
#(
	parameter int ADDR_W = ADDR_WIDTH_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_n_i,
	input wire logic counter_step_load_i,
	input wire logic write_n_i,
	input wire logic lane0_store_n_i,
	input wire logic lane1_store_n_i,
	input wire logic lane2_store_n_i,
	input wire logic lane3_store_n_i,
	input wire logic select_first_n_i,
	input wire logic select_second_i,
	input wire logic select_third_n_i,
	input wire logic [1:0] burst_start_bits_i,
	input wire logic [ADDR_W-3:0] addr_high_i,
	input wire logic out_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic pass_thru_select_n_i,
	input wire logic seq_order_pick_n_i,
	input wire logic [LANE_WIDTH-1:0] lane0_io_i,
	input wire logic [LANE_WIDTH-1:0] lane1_io_i,
	input wire logic [LANE_WIDTH-1:0] lane2_io_i,
	input wire logic [LANE_WIDTH-1:0] lane3_io_i,
	output logic [LANE_WIDTH-1:0] lane0_io_o,
	output logic [LANE_WIDTH-1:0] lane1_io_o,
	output logic [LANE_WIDTH-1:0] lane2_io_o,
	output logic [LANE_WIDTH-1:0] lane3_io_o,
	output logic lane_io_oe_o,
	output logic standby_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_ADDR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// ****************************************
	// Elaboration check
	// ****************************************
	generate
		if (ADDR_W < 3 || ADDR_W > 24) begin : g_bad_width
			$error("sbsp_port: ADDR_W must lie between 3 and 24");
		end
	endgenerate

	// ****************************************
	// Declarations
	// ****************************************
	sbsp_mem_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_WIDTH), .LANES(LANE_COUNT)) mem_bus ();

	logic [3:0] async_raw;
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic [3:0] sync_c;
	logic [3:0] sync_f;
	logic oe_n_f;
	logic sleep_f;
	logic pipelined;
	logic linear;

	logic [31:0] control;
	logic host_hold;
	logic step_edge;

	logic burst_on;
	logic burst_wr;
	logic [1:0] burst_start;
	logic [1:0] burst_step;
	logic [ADDR_W-3:0] burst_high;
	logic next_burst_on;
	logic next_burst_wr;
	logic [1:0] next_burst_start;
	logic [1:0] next_burst_step;
	logic [ADDR_W-3:0] next_burst_high;
	logic issue;
	logic selected;
	logic [1:0] low_bits;
	logic [LANE_COUNT-1:0] lanes_act;
	logic rd_op;
	logic wr_op;

	logic w1_valid;
	logic [ADDR_W-1:0] w1_addr;
	logic [LANE_COUNT-1:0] w1_lanes;
	logic w2_valid;
	logic [ADDR_W-1:0] w2_addr;
	logic [LANE_COUNT-1:0] w2_lanes;

	logic r1_valid;
	logic r2_valid;
	logic next_r1_valid;
	logic next_r2_valid;
	logic [DATA_WIDTH-1:0] pipe_data;
	logic [DATA_WIDTH-1:0] out_data;

	// ****************************************
	// Asynchronous pins: three stages, change on agreement
	// ****************************************
	assign async_raw = {seq_order_pick_n_i, pass_thru_select_n_i, sleep_request_i, out_enable_n_i};

	generate
		for (genvar g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					sync_a[g] <= SYNC_RESET[g];
					sync_b[g] <= SYNC_RESET[g];
					sync_c[g] <= SYNC_RESET[g];
					sync_f[g] <= SYNC_RESET[g];
				end else begin
					sync_a[g] <= async_raw[g];
					sync_b[g] <= sync_a[g];
					sync_c[g] <= sync_b[g];
					if (sync_b[g] == sync_c[g]) begin
						sync_f[g] <= sync_c[g];
					end
				end
			end
		end
	endgenerate

	assign oe_n_f = sync_f[SYNC_OE_N];
	assign sleep_f = sync_f[SYNC_SLEEP];
	assign pipelined = sync_f[SYNC_PASS_N];
	assign linear = !sync_f[SYNC_ORDER_N];

	// ****************************************
	// Edge qualification
	// ****************************************
	assign host_hold = control[CONTROL_HOLD_BIT];
	assign step_edge = !clk_en_n_i && !host_hold && !sleep_f;

	// ****************************************
	// Command decode and burst counter
	// ****************************************
	assign selected = !select_first_n_i && select_second_i && !select_third_n_i;
	assign lanes_act = ~{lane3_store_n_i, lane2_store_n_i, lane1_store_n_i, lane0_store_n_i};

	always_comb begin
		next_burst_on = burst_on;
		next_burst_wr = burst_wr;
		next_burst_start = burst_start;
		next_burst_step = burst_step;
		next_burst_high = burst_high;
		issue = 1'b0;
		if (!counter_step_load_i) begin
			if (selected) begin
				next_burst_on = 1'b1;
				next_burst_wr = !write_n_i;
				next_burst_start = burst_start_bits_i;
				next_burst_step = 2'b00;
				next_burst_high = addr_high_i;
				issue = 1'b1;
			end else begin
				next_burst_on = 1'b0;
			end
		end else if (burst_on) begin
			next_burst_step = burst_step + 2'b01;
			issue = 1'b1;
		end
	end

	assign low_bits = linear ? next_burst_start + next_burst_step : next_burst_start ^ next_burst_step;
	assign rd_op = issue && !next_burst_wr;
	assign wr_op = issue && next_burst_wr && (|lanes_act);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			burst_on <= 1'b0;
			burst_wr <= 1'b0;
			burst_start <= 2'b00;
			burst_step <= 2'b00;
			burst_high <= '0;
		end else if (step_edge) begin
			burst_on <= next_burst_on;
			burst_wr <= next_burst_wr;
			burst_start <= next_burst_start;
			burst_step <= next_burst_step;
			burst_high <= next_burst_high;
		end
	end

	// ****************************************
	// Late write pipeline
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w1_valid <= 1'b0;
			w1_addr <= '0;
			w1_lanes <= '0;
			w2_valid <= 1'b0;
			w2_addr <= '0;
			w2_lanes <= '0;
		end else if (step_edge) begin
			w1_valid <= wr_op;
			w1_addr <= {next_burst_high, low_bits};
			w1_lanes <= lanes_act;
			w2_valid <= w1_valid;
			w2_addr <= w1_addr;
			w2_lanes <= w1_lanes;
		end
	end

	// Write commits on the edge that carries its data
	always_comb begin
		if (pipelined) begin
			mem_bus.wr_en = step_edge && w2_valid;
			mem_bus.wr_addr = w2_addr;
			mem_bus.wr_lanes = w2_lanes;
		end else begin
			mem_bus.wr_en = step_edge && w1_valid;
			mem_bus.wr_addr = w1_addr;
			mem_bus.wr_lanes = w1_lanes;
		end
	end

	assign mem_bus.wr_data = {lane3_io_i, lane2_io_i, lane1_io_i, lane0_io_i};

	// ****************************************
	// Read path
	// ****************************************
	assign mem_bus.rd_en = step_edge && rd_op;
	assign mem_bus.rd_addr = {next_burst_high, low_bits};

	assign next_r1_valid = step_edge ? rd_op : r1_valid;
	assign next_r2_valid = step_edge ? r1_valid : r2_valid;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r1_valid <= 1'b0;
			r2_valid <= 1'b0;
			pipe_data <= '0;
		end else begin
			r1_valid <= next_r1_valid;
			r2_valid <= next_r2_valid;
			if (step_edge && r1_valid) begin
				pipe_data <= mem_bus.rd_data;
			end
		end
	end

	assign out_data = pipelined ? pipe_data : mem_bus.rd_data;
	assign lane0_io_o = out_data[0*LANE_WIDTH +: LANE_WIDTH];
	assign lane1_io_o = out_data[1*LANE_WIDTH +: LANE_WIDTH];
	assign lane2_io_o = out_data[2*LANE_WIDTH +: LANE_WIDTH];
	assign lane3_io_o = out_data[3*LANE_WIDTH +: LANE_WIDTH];

	// ****************************************
	// Output drivers and standby
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lane_io_oe_o <= 1'b0;
			standby_o <= 1'b0;
		end else begin
			// Only read slots drive, so write cycles stay off
			lane_io_oe_o <= !oe_n_f && !sleep_f && (pipelined ? next_r2_valid : next_r1_valid);
			standby_o <= sleep_f;
		end
	end

	// ****************************************
	// Wishbone register slave
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control <= CONTROL_RESET;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == CONTROL_OFFSET) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) begin
					control[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h_0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= 32'h_0000_0000;
			if (!wb_we_i && wb_adr_i == STATUS_OFFSET) begin
				wb_dat_o[STATUS_PIPELINED_BIT] <= pipelined;
				wb_dat_o[STATUS_LINEAR_BIT] <= linear;
				wb_dat_o[STATUS_SLEEP_BIT] <= sleep_f;
				wb_dat_o[STATUS_BURST_ON_BIT] <= burst_on;
				wb_dat_o[STATUS_BURST_WR_BIT] <= burst_wr;
				wb_dat_o[STATUS_DRIVING_BIT] <= lane_io_oe_o;
				wb_dat_o[STATUS_STEP_POS +: 2] <= burst_step;
			end else if (!wb_we_i && wb_adr_i == CONTROL_OFFSET) begin
				wb_dat_o <= control;
			end
		end
	end

	// ****************************************
	// Storage
	// ****************************************
	sbsp_mem #(.ADDR_W(ADDR_W)) u_mem (
		.clk_i(clk_i),
		.m(mem_bus.mem)
	);

endmodule // sbsp_port

// ==== include/sbsp_pkg.sv ====
package sbsp_pkg;

	// ****************************************
	// Data bus shape
	// ****************************************
	localparam int LANE_COUNT = 4;
	localparam int LANE_WIDTH = 9;
	localparam int DATA_WIDTH = LANE_COUNT * LANE_WIDTH;
	localparam int BURST_BITS = 2;
	localparam int ADDR_WIDTH_DEFAULT = 10;

	// ****************************************
	// Synchroniser reset levels: out enable, sleep, mode strap, order strap
	// ****************************************
	localparam logic [3:0] SYNC_RESET = 4'h_d;
	localparam int SYNC_OE_N = 0;
	localparam int SYNC_SLEEP = 1;
	localparam int SYNC_PASS_N = 2;
	localparam int SYNC_ORDER_N = 3;

	// ****************************************
	// Wishbone register map
	// ****************************************
	localparam int WB_ADDR_WIDTH = 8;
	localparam logic [7:0] STATUS_OFFSET = 8'h_00;
	localparam logic [7:0] CONTROL_OFFSET = 8'h_04;
	localparam int STATUS_PIPELINED_BIT = 0;
	localparam int STATUS_LINEAR_BIT = 1;
	localparam int STATUS_SLEEP_BIT = 2;
	localparam int STATUS_BURST_ON_BIT = 3;
	localparam int STATUS_BURST_WR_BIT = 4;
	localparam int STATUS_DRIVING_BIT = 5;
	localparam int STATUS_STEP_POS = 8;
	localparam int CONTROL_HOLD_BIT = 0;
	localparam logic [31:0] CONTROL_RESET = 32'h_0000_0000;

endpackage

// ==== include/sbsp_mem_if.sv ====
interface sbsp_mem_if #(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 36,
	parameter int LANES = 4
);
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic wr_en;
	logic [LANES-1:0] wr_lanes;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;

	modport port (output rd_en, output rd_addr, input rd_data,
		output wr_en, output wr_lanes, output wr_addr, output wr_data);
	modport mem (input rd_en, input rd_addr, output rd_data,
		input wr_en, input wr_lanes, input wr_addr, input wr_data);
endinterface

// ==== hdl/sbsp_mem.sv ====
module sbsp_mem
	import sbsp_pkg::*;
#(
	parameter int ADDR_W = ADDR_WIDTH_DEFAULT
) (
	input wire logic clk_i,
	sbsp_mem_if.mem m
);

	// ****************************************
	// Storage array with per-lane writes
	// ****************************************
	logic [DATA_WIDTH-1:0] store [0:(1<<ADDR_W)-1];

	always_ff @(posedge clk_i) begin
		if (m.wr_en) begin
			for (int i = 0; i < LANE_COUNT; i++) begin
				if (m.wr_lanes[i]) begin
					store[m.wr_addr][i*LANE_WIDTH +: LANE_WIDTH] <= m.wr_data[i*LANE_WIDTH +: LANE_WIDTH];
				end
			end
		end
	end

	// ****************************************
	// Registered read port
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (m.rd_en) begin
			m.rd_data <= store[m.rd_addr];
		end
	end

endmodule // sbsp_mem

// ==== testbench/sbsp_port_monitor.sv ====
module sbsp_port_monitor
	import sbsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_n_i,
	input wire logic counter_step_load_i,
	input wire logic write_n_i,
	input wire logic select_first_n_i,
	input wire logic select_second_i,
	input wire logic select_third_n_i,
	input wire logic out_enable_n_i,
	input wire logic sleep_request_i,
	input wire logic pass_thru_select_n_i,
	input wire logic [LANE_WIDTH-1:0] lane0_io_o,
	input wire logic [LANE_WIDTH-1:0] lane1_io_o,
	input wire logic [LANE_WIDTH-1:0] lane2_io_o,
	input wire logic [LANE_WIDTH-1:0] lane3_io_o,
	input wire logic lane_io_oe_o,
	input wire logic standby_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic sel = !select_first_n_i && select_second_i && !select_third_n_i;
	wire logic ld = !clk_en_n_i && !counter_step_load_i;
	sequence settled;
		(!out_enable_n_i && !sleep_request_i && $stable(pass_thru_select_n_i)) [*6];
	endsequence
	sequence read_load;
		ld && sel && write_n_i;
	endsequence
	sequence write_load;
		ld && sel && !write_n_i;
	endsequence
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	stall_hold_a: assert property (settled ##0 clk_en_n_i |=> $stable(lane_io_oe_o) && $stable(lane0_io_o))
		else $error("output moved in stall");
	pipe_read_a: assert property (settled ##0 read_load ##0 pass_thru_select_n_i ##1 !clk_en_n_i |=> lane_io_oe_o)
		else $error("pipelined read not driven");
	flow_read_a: assert property (settled ##0 read_load ##0 !pass_thru_select_n_i |=> lane_io_oe_o)
		else $error("flow read not driven");
	pipe_write_a: assert property (settled ##0 write_load ##0 pass_thru_select_n_i ##1 !clk_en_n_i |=> !lane_io_oe_o)
		else $error("driving on write");
	flow_write_a: assert property (settled ##0 write_load ##0 !pass_thru_select_n_i |=> !lane_io_oe_o)
		else $error("driving on flow write");
	deselect_off_a: assert property (settled ##0 !pass_thru_select_n_i ##0 (ld && !sel) |=> !lane_io_oe_o)
		else $error("driving when deselected");
	oe_force_a: assert property (out_enable_n_i [*6] |-> !lane_io_oe_o)
		else $error("drivers on with enable off");
	sleep_off_a: assert property (sleep_request_i [*6] |-> standby_o && !lane_io_oe_o)
		else $error("no standby");
endmodule // sbsp_port_monitor

bind sbsp_port sbsp_port_monitor mon_u (.*);

// ==== testbench/sbsp_ctrl_model.sv ====
module sbsp_ctrl_model
	import sbsp_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clk_en_n_i,
	input wire logic counter_step_load_i,
	input wire logic write_n_i,
	input wire logic select_first_n_i,
	input wire logic select_second_i,
	input wire logic select_third_n_i,
	input wire logic pass_thru_select_n_i,
	input wire logic [DATA_WIDTH-1:0] wdata_i,
	output logic [LANE_WIDTH-1:0] lane0_io_i,
	output logic [LANE_WIDTH-1:0] lane1_io_i,
	output logic [LANE_WIDTH-1:0] lane2_io_i,
	output logic [LANE_WIDTH-1:0] lane3_io_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic on = 0;
	logic wr = 0;
	logic [DATA_WIDTH:0] d1 = 0;
	logic [DATA_WIDTH:0] d2 = 0;
	logic [DATA_WIDTH-1:0] last = 0;
	wire logic sel = !select_first_n_i && select_second_i && !select_third_n_i;
	wire logic slot = counter_step_load_i ? on && wr : sel && !write_n_i;
	wire logic [DATA_WIDTH:0] cur = pass_thru_select_n_i ? d2 : d1;
	// Write data follows its command by one or two taken edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			on <= 0;
			d1 <= 0;
			d2 <= 0;
		end else if (!clk_en_n_i) begin
			if (!counter_step_load_i) begin
				on <= sel;
				wr <= !write_n_i;
			end
			d1 <= {slot, wdata_i};
			d2 <= d1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (cur[DATA_WIDTH]) begin
			last <= cur[DATA_WIDTH-1:0];
		end
	end
	// Idle bus shows the inverse of the last word
	assign {lane3_io_i, lane2_io_i, lane1_io_i, lane0_io_i} = cur[DATA_WIDTH] ? cur[DATA_WIDTH-1:0] : ~last;
endmodule // sbsp_ctrl_model

// ==== testbench/sync_burst_sram_port_bench.sv ====
module sync_burst_sram_port_bench;
	import sbsp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, clk_en_n_i = 0, counter_step_load_i = 0, write_n_i = 1, out_enable_n_i = 0;
	logic lane0_store_n_i = 1, lane1_store_n_i = 1, lane2_store_n_i = 1, lane3_store_n_i = 1, sleep_request_i = 0;
	logic select_first_n_i = 0, select_second_i = 0, select_third_n_i = 0, pass_thru_select_n_i = 1;
	logic seq_order_pick_n_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, lane_io_oe_o, standby_o, wb_ack_o;
	logic [1:0] burst_start_bits_i = 0;
	logic [5:0] addr_high_i = 6'h_15;
	logic [7:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, wb_dat_o, q;
	logic [LANE_WIDTH-1:0] lane0_io_i, lane1_io_i, lane2_io_i, lane3_io_i, lane0_io_o, lane1_io_o, lane2_io_o, lane3_io_o;
	logic [DATA_WIDTH-1:0] wdata_i = 0;
	logic [DATA_WIDTH:0] h1 = 0, h2 = 0, pend = 0;
	logic prev_st = 0;
	int fail_count = 0, checks_done = 0;
	always #5 clk_i = ~clk_i;
	sbsp_port #(.ADDR_W(8)) dut_u (.*);
	sbsp_ctrl_model model_u (.*);
	task automatic chk(input string n, input logic [35:0] s, input logic [35:0] e);
		checks_done++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'h_f;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			complete_run();
		end
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
	endtask
	// ****************************************
	// One bus cycle: judge the output, then drive the next command
	// ****************************************
	task automatic step(input logic st, ld, wr, input logic [1:0] ds, sb, input logic [3:0] ln,
		input logic [35:0] wd, input logic [36:0] ex);
		logic [36:0] e;
		@(posedge clk_i);
		e = pass_thru_select_n_i ? h2 : h1;
		chk("drive", lane_io_oe_o, e[36]);
		if (e[36]) chk("data", {lane3_io_o, lane2_io_o, lane1_io_o, lane0_io_o}, e[35:0]);
		if (!prev_st) begin
			h2 = h1;
			h1 = pend;
		end
		pend = ex;
		prev_st = st;
		clk_en_n_i <= st;
		counter_step_load_i <= !ld;
		write_n_i <= !wr;
		select_first_n_i <= ds == 1;
		select_second_i <= ds != 2;
		select_third_n_i <= ds == 3;
		burst_start_bits_i <= sb;
		{lane3_store_n_i, lane2_store_n_i, lane1_store_n_i, lane0_store_n_i} <= ln;
		wdata_i <= wd;
	endtask
	task automatic reg_test;
		wb(0, STATUS_OFFSET, 0);
		chk("status", q[9:0], 10'h_001);
		wb(1, STATUS_OFFSET, 32'h_ffff_ffff);
		wb(0, STATUS_OFFSET, 0);
		chk("status ro", q[9:0], 10'h_001);
		wb(0, CONTROL_OFFSET, 0);
		chk("control reset", q, CONTROL_RESET);
		wb(1, CONTROL_OFFSET, 32'h_0000_0001);
		wb(0, CONTROL_OFFSET, 0);
		chk("control", q, 32'h_0000_0001);
		wb(1, CONTROL_OFFSET, 0);
		wb(1, 8'h_08, 32'h_ffff_ffff);
		wb(0, 8'h_08, 0);
		chk("unmapped", q, 0);
		$display("register test done");
	endtask
	task automatic burst_mode(input logic pipe);
		logic [35:0] nv = 36'h_2_4681_3579;
		logic [35:0] m = 36'h_0_07fc_01ff;
		logic [1:0] rs;
		int k;
		rs = pipe ? 2'h_0 : 2'h_2;
		pass_thru_select_n_i <= pipe;
		seq_order_pick_n_i <= pipe;
		addr_high_i <= pipe ? 6'h_2a : 6'h_15;
		repeat (6) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
		for (int i = 0; i < 4; i++) step(0, i == 0, 1, 0, 1, 4'h_0, 36'h_9_8765_4320 + 36'(i), 0);
		for (int p = 0; p < 2; p++) begin
			for (int j = 0; j < 4; j++) begin
				k = pipe ? j ^ 1 : (j + 1) % 4;
				step(0, j == 0, 0, 0, rs, 4'h_f, 0, {1'b1, (p == 1 && j == 0) ? (nv & m) |
					((36'h_9_8765_4320 + 36'(k)) & ~m) : 36'h_9_8765_4320 + 36'(k)});
				if (j == 1) step(1, 0, 0, 0, 0, 4'h_f, 0, 0);
			end
			if (p == 0) begin
				step(0, 1, 1, 0, rs, 4'h_a, nv, 0);
				step(0, 1, 1, 0, rs ^ 2'h_2, 4'h_f, nv, 0);
				for (int d = 1; d < 4; d++) step(0, 1, 0, 2'(d), 0, 4'h_f, 0, 0);
				step(0, 0, 0, 0, 0, 4'h_f, 0, 0);
			end
		end
		repeat (3) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
		$display("burst test done mode %0d", pipe);
	endtask
	task automatic async_off;
		for (int k = 0; k < 2; k++) begin
			out_enable_n_i <= k == 0;
			sleep_request_i <= k == 1;
			repeat (5) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
			repeat (3) step(0, 1, 0, 0, 2, 4'h_f, 0, 0);
			chk("standby", standby_o, 36'(k));
			out_enable_n_i <= 0;
			sleep_request_i <= 0;
			repeat (6) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
		end
		$display("async test done");
	endtask
	// ****************************************
	// Register hold: a write under hold must not land
	// ****************************************
	task automatic hold_test;
		wb(1, CONTROL_OFFSET, 32'h_0000_0001);
		step(0, 1, 1, 0, 1, 4'h_0, 36'h_2_4681_3579, 0);
		repeat (3) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
		wb(1, CONTROL_OFFSET, 32'h_0000_0000);
		repeat (3) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
		step(0, 1, 0, 0, 1, 4'h_f, 0, {1'b1, 36'h_9_8765_4320});
		repeat (3) step(0, 1, 0, 2, 0, 4'h_f, 0, 0);
		$display("hold test done");
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		repeat (6) @(posedge clk_i);
		reg_test();
		burst_mode(0);
		burst_mode(1);
		async_off();
		hold_test();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		complete_run();
	end
endmodule // sync_burst_sram_port_bench
